/* File: dsl_pkg.sv */
// constants, carriers and state types for the dual serial line units
package dsl_pkg;

    // =========================================================
    // register map (byte addresses)
    localparam logic [5:0] DSL_BASE_CONSOLE = 6'h00;
    localparam logic [5:0] DSL_BASE_USER    = 6'h20;
    localparam logic [4:0] DSL_OFS_RCSR     = 5'h00;
    localparam logic [4:0] DSL_OFS_RBUF     = 5'h04;
    localparam logic [4:0] DSL_OFS_TX_CONTROL_STATUS     = 5'h08;
    localparam logic [4:0] DSL_OFS_XBUF     = 5'h0c;
    localparam logic [4:0] DSL_OFS_DIV      = 5'h10;

    // =========================================================
    // field positions
    localparam int DSL_DONE_BIT  = 7;
    localparam int DSL_READY_BIT = 7;
    localparam int DSL_MAINT_BIT = 2;
    localparam int DSL_BREAK_BIT = 0;
    localparam int DSL_ERR_BIT   = 15;
    localparam int DSL_OE_BIT    = 14;
    localparam int DSL_FE_BIT    = 13;
    localparam int DSL_PE_BIT    = 12;

    // =========================================================
    // reset values, timing counts and test characters
    localparam logic [15:0] DSL_DIV_RESET  = 16'h0082;
    localparam logic [3:0]  DSL_LAST_PHASE = 4'hf;
    localparam logic [3:0]  DSL_MID_PHASE  = 4'h7;
    localparam logic [3:0]  DSL_DATA_BITS  = 4'h8;
    localparam logic [7:0]  DSL_CHAR_U     = 8'h55;
    localparam logic [7:0]  DSL_CHAR_STAR  = 8'h2a;

    // =========================================================
    // pins that arrive from outside the clock domain
    typedef struct packed {
        logic [1:0] serialIn;
        logic       consoleParityEnableStrap;
        logic       consoleParitySenseStrap;
        logic       stopBitCountStrap;
        logic       parityEnableStrap;
        logic       userParitySenseStrap;
        logic       fieldserviceLoopSwitch;
        logic       keyswitchLocal;
        logic       consoleDebugMode;
    } dsl_pins_t;

    // one serial line unit
    typedef struct packed {
        logic [15:0] divisor;
        logic [15:0] divCnt;
        logic        txBusy;
        logic [3:0]  txPhase;
        logic [3:0]  txBitsLeft;
        logic [11:0] txShift;
        logic        txLine;
        logic        holdFree;
        logic [7:0]  holdData;
        logic        ctlBit;
        logic        serialOut;
        logic        rxPrev;
        logic        rxActive;
        logic [3:0]  rxPhase;
        logic [3:0]  rxIdx;
        logic [10:0] rxBits;
        logic [7:0]  rxData;
        logic        rxDone;
        logic        oe;
        logic        fe;
        logic        pe;
    } dsl_unit_t;

    // whole block state
    typedef struct packed {
        dsl_unit_t [1:0] unit;
        dsl_pins_t       sync1;
        dsl_pins_t       sync2;
        logic            busAck;
        logic            waitReq;
        logic [31:0]     rdData;
        logic            halt;
        logic            cmdValid;
        logic [7:0]      cmdData;
    } dsl_state_t;

endpackage : dsl_pkg

/* File: dsl_top.sv */
// dual serial line units: console unit and user unit behind an avalon slave
//
// The register addresses and the Avalon-MM slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none

module dsl_top (
    // clock and reset
    input  wire logic                mclk,
    input  wire logic                resetn,
    // avalon-mm slave
    input  wire logic [5:0]          avsAddress,
    input  wire logic                avsRead,
    input  wire logic                avsWrite,
    input  wire logic [3:0]          avsByteenable,
    input  wire logic [31:0]         avsWritedata,
    output var  logic [31:0]         avsReaddata,
    output var  logic                avsWaitrequest,
    // asynchronous pins and straps
    input  wire dsl_pkg::dsl_pins_t  pinsIn,
    // serial lines, index 0 console, 1 user
    output var  logic [1:0]          serialOut,
    // receive status lines and console transmit holding status
    output var  logic [1:0]          rxParityFault,
    output var  logic [1:0]          rxFramingFault,
    output var  logic [1:0]          rxOverrunFault,
    output var  logic                consoleTxHoldingFree,
    // processor side
    output var  logic                haltRequest,
    output var  logic                cmdValid,
    output var  logic [7:0]          cmdData
);
    import dsl_pkg::*;

    dsl_state_t st;
    dsl_state_t next_st;

    // =========================================================
    // next state
    always_comb begin
        dsl_pins_t  pins;
        logic       unitSel;
        logic [4:0] regOfs;
        logic [1:0] rdClr;
        logic [1:0] txLoad;
        logic [31:0] rdVal;
        logic       tick;
        logic       pEn;
        logic       pOdd;
        logic       twoStop;
        logic       txPar;
        logic       rxIn;
        logic [7:0] rxByte;
        logic [3:0] lastIdx;
        next_st  = st;
        pins     = st.sync2;
        unitSel  = avsAddress[5];
        regOfs   = avsAddress[4:0];
        rdClr    = 2'b00;
        txLoad   = 2'b00;
        rdVal    = 32'h0000_0000;
        tick     = 1'b0;
        pEn      = 1'b0;
        pOdd     = 1'b0;
        twoStop  = 1'b0;
        txPar    = 1'b0;
        rxIn     = 1'b1;
        rxByte   = 8'h00;
        lastIdx  = 4'h0;

        // two-stage synchroniser for every pin
        next_st.sync1    = pinsIn;
        next_st.sync2    = st.sync1;
        next_st.cmdValid = 1'b0;

        // read multiplexer, sampled into readdata as waitrequest drops
        unique case (regOfs)
            DSL_OFS_RCSR: begin
                rdVal[DSL_DONE_BIT] = st.unit[unitSel].rxDone;
            end
            DSL_OFS_RBUF: begin
                rdVal[7:0]          = st.unit[unitSel].rxData;
                rdVal[DSL_OE_BIT]   = st.unit[unitSel].oe;
                rdVal[DSL_FE_BIT]   = st.unit[unitSel].fe;
                rdVal[DSL_PE_BIT]   = st.unit[unitSel].pe;
                rdVal[DSL_ERR_BIT]  = st.unit[unitSel].oe | st.unit[unitSel].fe
                                    | st.unit[unitSel].pe;
            end
            DSL_OFS_TX_CONTROL_STATUS: begin
                rdVal[DSL_READY_BIT] = st.unit[unitSel].holdFree;
                if (unitSel == 1'b0) begin
                    rdVal[DSL_MAINT_BIT] = st.unit[0].ctlBit;
                end else begin
                    rdVal[DSL_BREAK_BIT] = st.unit[1].ctlBit;
                end
            end
            DSL_OFS_DIV: begin
                rdVal[15:0] = st.unit[unitSel].divisor;
            end
            default: begin
                rdVal = 32'h0000_0000; // unmapped and write-only read zero
            end
        endcase

        // bus handshake: one wait cycle, then one acknowledge cycle
        if (st.busAck) begin
            next_st.busAck  = 1'b0;
            next_st.waitReq = 1'b1;
            if (avsWrite) begin
                unique case (regOfs)
                    DSL_OFS_TX_CONTROL_STATUS: begin
                        if (avsByteenable[0]) begin
                            // loop bit only under program control
                            if (unitSel == 1'b0) begin
                                next_st.unit[0].ctlBit = avsWritedata[DSL_MAINT_BIT];
                            end else begin
                                next_st.unit[1].ctlBit = avsWritedata[DSL_BREAK_BIT];
                            end
                        end
                    end
                    DSL_OFS_XBUF: begin
                        txLoad[unitSel] = avsByteenable[0];
                    end
                    DSL_OFS_DIV: begin
                        if (avsByteenable[0]) begin
                            next_st.unit[unitSel].divisor[7:0] = avsWritedata[7:0];
                        end
                        if (avsByteenable[1]) begin
                            next_st.unit[unitSel].divisor[15:8] = avsWritedata[15:8];
                        end
                    end
                    default: begin
                        next_st.busAck = 1'b0; // unmapped writes are dropped
                    end
                endcase
            end
            if (avsRead && regOfs == DSL_OFS_RBUF) begin
                rdClr[unitSel] = 1'b1;
            end
        end else if (avsRead || avsWrite) begin
            next_st.busAck  = 1'b1;
            next_st.waitReq = 1'b0;
            next_st.rdData  = avsRead ? rdVal : 32'h0000_0000;
        end

        // both units share one engine; differences keyed on the index
        for (int u = 0; u < 2; u++) begin
            // 16x oversampling tick from the baud divisor
            tick = (st.unit[u].divCnt == 16'h0000);
            next_st.unit[u].divCnt = tick ? 16'(st.unit[u].divisor - 16'h0001)
                                          : 16'(st.unit[u].divCnt - 16'h0001);

            // character format straps
            pEn     = (u == 0) ? pins.consoleParityEnableStrap
                               : pins.parityEnableStrap;
            pOdd    = (u == 0) ? pins.consoleParitySenseStrap
                               : pins.userParitySenseStrap;
            twoStop = ~pins.stopBitCountStrap;
            txPar   = pOdd ? ~(^st.unit[u].holdData)
                           : (^st.unit[u].holdData);

            // transmitter: move held byte into the shift register
            if (!st.unit[u].txBusy && !st.unit[u].holdFree) begin
                next_st.unit[u].txShift = pEn
                    ? {2'b11, txPar, st.unit[u].holdData, 1'b0}
                    : {3'b111, st.unit[u].holdData, 1'b0};
                next_st.unit[u].txBitsLeft = 4'(DSL_DATA_BITS + 4'h1
                    + {3'b000, pEn} + (twoStop ? 4'h2 : 4'h1));
                next_st.unit[u].txPhase  = 4'h0;
                next_st.unit[u].txBusy   = 1'b1;
                next_st.unit[u].holdFree = 1'b1;
            end else if (st.unit[u].txBusy && tick) begin
                next_st.unit[u].txPhase = 4'(st.unit[u].txPhase + 4'h1);
                if (st.unit[u].txPhase == DSL_LAST_PHASE) begin
                    next_st.unit[u].txShift =
                        {1'b1, st.unit[u].txShift[11:1]};
                    next_st.unit[u].txBitsLeft =
                        4'(st.unit[u].txBitsLeft - 4'h1);
                    if (st.unit[u].txBitsLeft == 4'h1) begin
                        next_st.unit[u].txBusy = 1'b0;
                    end
                end
            end

            // receive input selector; only the console has the loop
            if (u == 0 && st.unit[0].ctlBit) begin
                rxIn = st.unit[0].txLine;
            end else begin
                rxIn = pins.serialIn[u];
            end
            next_st.unit[u].rxPrev = rxIn;

            // read of the buffer clears done and overrun first
            if (rdClr[u]) begin
                next_st.unit[u].rxDone = 1'b0;
                next_st.unit[u].oe     = 1'b0;
            end

            // receiver: start on mark-to-space, sample mid bit
            lastIdx = 4'(DSL_DATA_BITS + 4'h1 + {3'b000, pEn});
            if (!st.unit[u].rxActive) begin
                if (st.unit[u].rxPrev && !rxIn) begin
                    next_st.unit[u].rxActive = 1'b1;
                    next_st.unit[u].rxPhase  = 4'h0;
                    next_st.unit[u].rxIdx    = 4'h0;
                end
            end else if (tick) begin
                next_st.unit[u].rxPhase = 4'(st.unit[u].rxPhase + 4'h1);
                if (st.unit[u].rxPhase == DSL_MID_PHASE) begin
                    next_st.unit[u].rxBits[st.unit[u].rxIdx] = rxIn;
                    next_st.unit[u].rxIdx = 4'(st.unit[u].rxIdx + 4'h1);
                    if (st.unit[u].rxIdx == 4'h0 && rxIn) begin
                        next_st.unit[u].rxActive = 1'b0; // glitch, not a start
                    end else if (st.unit[u].rxIdx == lastIdx) begin
                        // first stop bit only; the second is never looked at
                        next_st.unit[u].rxActive = 1'b0;
                        rxByte = st.unit[u].rxBits[8:1];
                        next_st.unit[u].fe = ~rxIn;
                        next_st.unit[u].pe = pEn
                            & ((^rxByte ^ st.unit[u].rxBits[9]) != pOdd);
                        if (u == 0 && pins.fieldserviceLoopSwitch) begin
                            // echo without the processor, swapping test characters
                            next_st.unit[0].holdFree = 1'b0;
                            if (rxByte == DSL_CHAR_U) begin
                                next_st.unit[0].holdData = DSL_CHAR_STAR;
                            end else if (rxByte == DSL_CHAR_STAR) begin
                                next_st.unit[0].holdData = DSL_CHAR_U;
                            end else begin
                                next_st.unit[0].holdData = rxByte;
                            end
                        end else if (u == 0 && pins.consoleDebugMode) begin
                            next_st.cmdValid = 1'b1;
                            next_st.cmdData  = rxByte;
                        end else begin
                            // done set wins over a clearing read in the same cycle; that read keeps overrun clear
                            next_st.unit[u].oe =
                                st.unit[u].rxDone & ~rdClr[u];
                            next_st.unit[u].rxData = rxByte;
                            next_st.unit[u].rxDone = 1'b1;
                        end
                    end
                end
            end

            // bus load last, so it wins over an echo in the same cycle
            if (txLoad[u]) begin
                next_st.unit[u].holdData = avsWritedata[7:0];
                next_st.unit[u].holdFree = 1'b0;
            end

            // line level: mark while idle; user break forces space
            next_st.unit[u].txLine = next_st.unit[u].txBusy
                ? next_st.unit[u].txShift[0] : 1'b1;
            next_st.unit[u].serialOut = next_st.unit[u].txLine
                & ~((u == 1) & next_st.unit[u].ctlBit);
        end

        // break on the console halts the processor in local
        next_st.halt = next_st.unit[0].fe & pins.keyswitchLocal;
    end

    // =========================================================
    // state register
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
            st.waitReq <= 1'b1;
            for (int u = 0; u < 2; u++) begin
                st.unit[u].divisor   <= DSL_DIV_RESET;
                st.unit[u].holdFree  <= 1'b1;
                st.unit[u].txLine    <= 1'b1;
                st.unit[u].serialOut <= 1'b1;
                st.unit[u].rxPrev    <= 1'b1;
                st.unit[u].txShift   <= 12'hfff;
            end
            st.sync1 <= '1;
            st.sync2 <= '1;
        end else begin
            st <= next_st;
        end
    end

    // =========================================================
    // outputs, all straight from state flops
    assign avsReaddata          = st.rdData;
    assign avsWaitrequest       = st.waitReq;
    assign serialOut            = {st.unit[1].serialOut, st.unit[0].serialOut};
    assign rxParityFault        = {st.unit[1].pe, st.unit[0].pe};
    assign rxFramingFault       = {st.unit[1].fe, st.unit[0].fe};
    assign rxOverrunFault       = {st.unit[1].oe, st.unit[0].oe};
    assign consoleTxHoldingFree = st.unit[0].holdFree;
    assign haltRequest          = st.halt;
    assign cmdValid             = st.cmdValid;
    assign cmdData              = st.cmdData;

endmodule : dsl_top

`default_nettype wire

/* File: dsl_props.sv */
// assertion checker for the dual serial line units
`timescale 1ns/10ps
`default_nettype none
module dsl_props (
    // clock and reset
    input wire logic              mclk,
    input wire logic              resetn,
    // register bus
    input wire logic [5:0]        avsAddress,
    input wire logic              avsRead,
    input wire logic              avsWrite,
    input wire logic              avsWaitrequest,
    // pins and status
    input wire dsl_pkg::dsl_pins_t pinsIn,
    input wire logic [1:0]        serialOut,
    input wire logic [1:0]        rxParityFault,
    input wire logic [1:0]        rxFramingFault,
    input wire logic [1:0]        rxOverrunFault,
    input wire logic              consoleTxHoldingFree,
    input wire logic              haltRequest,
    input wire logic              cmdValid
);
    import dsl_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    // =========================================================
    // bus steps: a request accepted at the edge where waitrequest is low
    sequence ackWrite(a);
        avsWrite && !avsWaitrequest && avsAddress == a;
    endsequence
    sequence ackRead(a);
        avsRead && !avsWaitrequest && avsAddress == a;
    endsequence

    // =========================================================
    // properties
    reset_idle_a: assert property (!$past(resetn) |-> serialOut == 2'b11)
        else $error("serial lines not at mark after reset");
    bus_answer_a: assert property ($rose(avsRead) |-> ##1 !avsWaitrequest ##1 avsWaitrequest)
        else $error("read not answered in one cycle");
    hold_load_a: assert property (ackWrite({1'b0, DSL_OFS_XBUF}) |=> !consoleTxHoldingFree)
        else $error("holding buffer not loaded by write");
    // a full holding buffer must drain within one character at the shortest divisor
    hold_drain_a: assert property (!consoleTxHoldingFree |-> ##[0:260] consoleTxHoldingFree)
        else $error("holding buffer never moved to shifter");
    halt_cause_a: assert property (haltRequest |-> rxFramingFault[0] || $past(rxFramingFault[0]))
        else $error("halt without framing fault");
    pe_gate_a: assert property ($rose(rxParityFault[0]) |-> $past(pinsIn.consoleParityEnableStrap, 3))
        else $error("console parity fault with parity off");
    pe_user_a: assert property ($rose(rxParityFault[1]) |-> $past(pinsIn.parityEnableStrap, 3))
        else $error("user parity fault with parity off");
    oe_clear_a: assert property (ackRead({1'b0, DSL_OFS_RBUF}) |=> !rxOverrunFault[0])
        else $error("overrun not cleared by buffer read");
    cmd_pulse_a: assert property (cmdValid |=> !cmdValid)
        else $error("command strobe longer than one cycle");
endmodule : dsl_props
`default_nettype wire

/* File: dsl_term_model.sv */
// serial terminal model on the far side of both line units
`timescale 1ns/10ps
`default_nettype none
module dsl_term_model #(
    parameter int BIT = 16
) (
    // clock
    input  wire logic       mclk,
    // lines from and to the device
    input  wire logic [1:0] devOut,
    output var  logic [1:0] devIn
);
    logic [9:0] got[$];   // unit, bit after data, data
    time        gotT[$];  // start bit times
    initial devIn = 2'b11;  // idle at mark between frames

    // =========================================================
    // one frame, lsb first, closing with mark so the next start is seen
    task automatic sendChar(input int u, input logic [7:0] d, input logic usePar,
                            input logic par, input logic stopBit);
        logic [11:0] f;
        f = usePar ? {1'b1, stopBit, par, d, 1'b0} : {2'b11, stopBit, d, 1'b0};
        for (int i = 0; i < 12; i++) begin
            @(posedge mclk);
            if (u == 0) devIn[0] <= f[i];
            else devIn[1] <= f[i];
            repeat (BIT - 1) @(posedge mclk);
        end
    endtask : sendChar

    // =========================================================
    // receivers: mid-bit sampling of data plus the following bit
    for (genvar u = 0; u < 2; u++) begin : rxSide
        logic [8:0] v;
        initial forever begin
            @(negedge devOut[u]);
            gotT.push_back($time);
            repeat (BIT + BIT / 2) @(posedge mclk);
            for (int i = 0; i < 9; i++) begin
                v[i] = devOut[u];
                repeat (BIT) @(posedge mclk);
            end
            got.push_back({1'(u), v});
            wait (devOut[u] === 1'b1);  // a break holds space; rearm only at mark
        end
    end
endmodule : dsl_term_model
`default_nettype wire

/* File: dsl_top_tb.sv */
// self-checking bench for the dual serial line units
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module dsl_top_tb;
    import dsl_pkg::*;
    localparam int BIT = 16;  // divisor 1 gives sixteen clocks a bit
    logic        mclk = 1'b0;
    logic        resetn = 1'b0;
    logic [5:0]  avsAddress = 6'h00;
    logic        avsRead = 1'b0;
    logic        avsWrite = 1'b0;
    logic [3:0]  avsByteenable = 4'h3;
    logic [31:0] avsWritedata = 32'h0;
    logic [31:0] avsReaddata, rd;
    logic        avsWaitrequest, consoleTxHoldingFree, haltRequest, cmdValid;
    dsl_pins_t   pins = '0;
    dsl_pins_t   pinsIn;
    logic [1:0]  termLine, serialOut, rxParityFault, rxFramingFault, rxOverrunFault;
    logic [7:0]  cmdData;
    logic [9:0]  ch;
    time         t0, t1;
    int          n;
    int          err_count = 0;
    int          check_count = 0;

    // =========================================================
    // clock, line merge and instances
    initial forever #25 mclk = ~mclk;
    always_comb begin
        pinsIn = pins;
        pinsIn.serialIn = termLine;
    end
    dsl_top uut (.mclk, .resetn, .avsAddress, .avsRead, .avsWrite, .avsByteenable,
        .avsWritedata, .avsReaddata, .avsWaitrequest, .pinsIn, .serialOut, .rxParityFault,
        .rxFramingFault, .rxOverrunFault, .consoleTxHoldingFree, .haltRequest, .cmdValid,
        .cmdData);
    dsl_term_model #(.BIT(BIT)) tm (.mclk, .devOut(serialOut), .devIn(termLine));

    // =========================================================
    // tasks
    task automatic close_out;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : close_out

    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [5:0] a, input logic [15:0] wd);
        int k;
        @(posedge mclk);
        avsAddress   <= a;
        avsWrite     <= wr;
        avsRead      <= !wr;
        avsWritedata <= {16'h0, wd};
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (avsWaitrequest !== 1'b0 && k < 50);
        rd = avsReaddata;
        avsRead  <= 1'b0;
        avsWrite <= 1'b0;
        if (avsWaitrequest !== 1'b0) begin
            err_count++;
            close_out();
        end
    endtask : bus

    task automatic waitChar(output logic [9:0] v, output time t);
        for (int k = 0; k < 4000 && tm.got.size() == 0; k++) @(posedge mclk);
        if (tm.got.size() == 0) begin
            err_count++;
            close_out();
        end else begin
            v = tm.got.pop_front();
            t = tm.gotT.pop_front();
        end
    endtask : waitChar

    // hang guard
    initial begin
        repeat (100000) @(posedge mclk);
        err_count++;
        close_out();
    end

    // =========================================================
    // main sequence
    initial begin
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        `CHK(serialOut, 2'b11)
        `CHK(consoleTxHoldingFree, 1'b1)
        bus(0, {1'b0, DSL_OFS_DIV}, 16'h0);
        `CHK(rd[15:0], DSL_DIV_RESET)
        bus(1, {1'b0, DSL_OFS_DIV}, 16'h1);
        bus(1, {1'b1, DSL_OFS_DIV}, 16'h1);
        bus(0, 6'h14, 16'h0);
        `CHK(rd, 32'h0)
        pins.consoleParityEnableStrap <= 1'b1;
        pins.consoleParitySenseStrap  <= 1'b1;
        // two bytes back to back: spacing of the starts shows the stop count
        for (int s = 0; s < 2; s++) begin
            pins.stopBitCountStrap <= s[0];
            // outlast the reset divisor count and the previous frame
            repeat (140) @(posedge mclk);
            bus(1, {1'b0, DSL_OFS_XBUF}, 16'h0041);
            bus(1, {1'b0, DSL_OFS_XBUF}, 16'h0043);
            bus(0, {1'b0, DSL_OFS_TX_CONTROL_STATUS}, 16'h0);
            `CHK(rd[DSL_READY_BIT], 1'b0)
            waitChar(ch, t0);
            `CHK(ch, {1'b0, ~^8'h41, 8'h41})
            waitChar(ch, t1);
            `CHK(ch, {1'b0, ~^8'h43, 8'h43})
            // one idle clock between frames while the next byte moves in
            `CHK(t1 - t0, time'(((12 - s) * BIT + 1) * 50))
        end
        tm.sendChar(0, 8'h3c, 1'b1, ~^8'h3c, 1'b1);
        bus(0, {1'b0, DSL_OFS_RCSR}, 16'h0);
        `CHK(rd[DSL_DONE_BIT], 1'b1)
        bus(0, {1'b0, DSL_OFS_RBUF}, 16'h0);
        `CHK(rd, 32'h003c)
        bus(0, {1'b0, DSL_OFS_RCSR}, 16'h0);
        `CHK(rd[DSL_DONE_BIT], 1'b0)
        tm.sendChar(0, 8'h3c, 1'b1, ^8'h3c, 1'b1);
        `CHK(rxParityFault, 2'b01)
        bus(0, {1'b0, DSL_OFS_RBUF}, 16'h0);
        `CHK(rd, 32'h903c)
        pins.consoleParityEnableStrap <= 1'b0;
        pins.keyswitchLocal <= 1'b1;
        repeat (6) @(posedge mclk);
        tm.sendChar(0, 8'h3c, 1'b0, 1'b0, 1'b0);
        `CHK(haltRequest, 1'b1)
        `CHK(rxFramingFault, 2'b01)
        bus(0, {1'b0, DSL_OFS_RBUF}, 16'h0);
        `CHK(rd, 32'ha03c)
        tm.sendChar(0, 8'h11, 1'b0, 1'b0, 1'b1);
        tm.sendChar(0, 8'h22, 1'b0, 1'b0, 1'b1);
        `CHK(rxOverrunFault, 2'b01)
        bus(0, {1'b0, DSL_OFS_RBUF}, 16'h0);
        `CHK(rd, 32'hc022)
        bus(1, {1'b0, DSL_OFS_TX_CONTROL_STATUS}, 16'h0004);
        bus(1, {1'b0, DSL_OFS_XBUF}, 16'h005a);
        repeat (12 * BIT) @(posedge mclk);
        bus(0, {1'b0, DSL_OFS_RBUF}, 16'h0);
        `CHK(rd, 32'h005a)
        bus(1, {1'b0, DSL_OFS_TX_CONTROL_STATUS}, 16'h0000);
        repeat (300) @(posedge mclk);
        tm.got.delete();
        tm.gotT.delete();
        pins.fieldserviceLoopSwitch <= 1'b1;
        repeat (6) @(posedge mclk);
        for (int i = 0; i < 2; i++) begin
            tm.sendChar(0, i ? DSL_CHAR_STAR : DSL_CHAR_U, 1'b0, 1'b0, 1'b1);
            waitChar(ch, t0);
            `CHK(ch, {2'b01, i ? DSL_CHAR_U : DSL_CHAR_STAR})
        end
        pins.fieldserviceLoopSwitch <= 1'b0;
        pins.consoleDebugMode <= 1'b1;
        repeat (6) @(posedge mclk);
        fork
            tm.sendChar(0, 8'h33, 1'b0, 1'b0, 1'b1);
            for (n = 0; n < 400 && cmdValid !== 1'b1; n++) @(posedge mclk);
        join
        `CHK(n < 400, 1'b1)
        `CHK(cmdData, 8'h33)
        bus(0, {1'b0, DSL_OFS_RCSR}, 16'h0);
        `CHK(rd[DSL_DONE_BIT], 1'b0)
        pins.consoleDebugMode <= 1'b0;
        pins.parityEnableStrap <= 1'b1;
        repeat (6) @(posedge mclk);
        bus(1, {1'b1, DSL_OFS_XBUF}, 16'h0007);
        waitChar(ch, t0);
        `CHK(ch, {1'b1, ^8'h07, 8'h07})
        tm.sendChar(1, 8'h07, 1'b1, ~^8'h07, 1'b1);
        bus(0, {1'b1, DSL_OFS_RBUF}, 16'h0);
        `CHK(rd, 32'h9007)
        pins.userParitySenseStrap <= 1'b1;
        repeat (6) @(posedge mclk);
        tm.sendChar(1, 8'h07, 1'b1, ~^8'h07, 1'b1);
        bus(0, {1'b1, DSL_OFS_RBUF}, 16'h0);
        `CHK(rd, 32'h0007)
        bus(1, {1'b1, DSL_OFS_TX_CONTROL_STATUS}, 16'h0001);
        repeat (20) @(posedge mclk);
        `CHK(serialOut[1], 1'b0)
        bus(1, {1'b1, DSL_OFS_TX_CONTROL_STATUS}, 16'h0000);
        repeat (300) @(posedge mclk);
        close_out();
    end
endmodule : dsl_top_tb

bind dsl_top dsl_props chk (.mclk, .resetn, .avsAddress, .avsRead, .avsWrite, .avsWaitrequest,
    .pinsIn, .serialOut, .rxParityFault, .rxFramingFault, .rxOverrunFault,
    .consoleTxHoldingFree, .haltRequest, .cmdValid);
`default_nettype wire
